// [rtl/quadrature_position_velocity.sv]
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Quadrature position and velocity decoder
// ======================================================================
module quadrature_position_velocity #(
   parameter int PRESC_W = qpv_pkg::PRESC_W
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire qpv_pkg::enc_pins_t enc_pins,
   input wire logic halt_req,
   input wire qpv_pkg::reg_req_t bus_req,
   output logic [qpv_pkg::DATA_W-1:0] rd_data,
   output logic event_pending,
   output logic direction_back
);

   localparam int DW = qpv_pkg::DATA_W;

   typedef struct packed {
      qpv_pkg::decoder_control_t ctl;
      logic [DW-1:0] pos;
      logic [DW-1:0] limit;
      logic [DW-1:0] reload;
      logic [DW-1:0] timer;
      logic [DW-1:0] count;
      logic [DW-1:0] speed;
      logic [qpv_pkg::EVT_W-1:0] raw;
      logic [qpv_pkg::EVT_W-1:0] mask;
      logic phase_seen;
      logic dir;
      logic [1:0] primed;
      qpv_pkg::enc_pins_t prev;
      logic [DW-1:0] rdata;
      logic pending;
   } qpv_state_t;

   qpv_state_t state_ff;
   qpv_state_t nxt_state;

   qpv_pkg::enc_pins_t pins_sync;
   qpv_pkg::enc_pins_t pins;
   logic a_chg, b_chg, home_rise, phase_err, step, fwd, dir_new, dir_flip;
   logic run, vel_run, presc_pulse, wr_pos, home_zero;
   logic [qpv_pkg::EVT_W-1:0] evt_set, evt_clr;

   if (PRESC_W != qpv_pkg::PRESC_W) begin : g_bad_presc
      $error("prescale select width must match the control word");
   end

   // Next position after one counted step, wrapping inside 0..limit.
   function automatic logic [DW-1:0] bump(input logic [DW-1:0] p, input logic [DW-1:0] lim,
                                           input logic up);
      if (up) begin
         bump = (p >= lim) ? '0 : p + DW'(1);
      end else begin
         bump = (p == '0) ? lim : p - DW'(1);
      end
   endfunction

   // ==================================================================
   // Pin conditioning
   // ==================================================================
   // Two flops per pin give the full clock to a quarter-rate input.
   enc_sync #(
      .W(3)
   ) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(enc_pins),
      .sync_out(pins_sync)
   );

   // Inversion is applied first, then the optional channel exchange.
   always_comb begin
      pins.home_pulse_input = pins_sync.home_pulse_input ^ state_ff.ctl.invert_home;
      pins.channel_a_input = pins_sync.channel_a_input ^ state_ff.ctl.invert_chan_a;
      pins.channel_b_input = pins_sync.channel_b_input ^ state_ff.ctl.invert_chan_b;
      if (state_ff.ctl.swap) begin
         pins.channel_a_input = pins_sync.channel_b_input ^ state_ff.ctl.invert_chan_b;
         pins.channel_b_input = pins_sync.channel_a_input ^ state_ff.ctl.invert_chan_a;
      end
   end

   // ==================================================================
   // Edge decoding
   // ==================================================================
   // History is trusted only once the synchroniser holds real pin levels and one
   // sample of them is kept, so an idle-high encoder does not look like an edge.
   always_comb begin
      a_chg = (&state_ff.primed) && (pins.channel_a_input != state_ff.prev.channel_a_input);
      b_chg = (&state_ff.primed) && (pins.channel_b_input != state_ff.prev.channel_b_input);
      home_rise = (&state_ff.primed) && pins.home_pulse_input && !state_ff.prev.home_pulse_input;
      run = state_ff.ctl.enable && !(state_ff.ctl.freeze_on_halt && halt_req);
      vel_run = run && state_ff.ctl.rate_capture_on;
      phase_err = 1'b0;
      dir_new = state_ff.dir;
      if (!state_ff.ctl.input_format_select) begin
         phase_err = a_chg && b_chg;
         step = !phase_err && (a_chg || (state_ff.ctl.edge_count_select && b_chg));
         // A moving away from B, or B moving onto A, means A leads.
         if (a_chg) begin
            fwd = pins.channel_a_input != pins.channel_b_input;
         end else begin
            fwd = pins.channel_a_input == pins.channel_b_input;
         end
         if (!phase_err && (a_chg || b_chg)) begin
            dir_new = !fwd;
         end
      end else begin
         step = pins.channel_a_input && a_chg;
         fwd = !pins.channel_b_input;
         if (step) begin
            dir_new = !fwd;
         end
      end
      // A reversal is the first edge whose sense differs from the last one, which
      // in quadrature format is a rise and fall on one channel with none between.
      dir_flip = run && (dir_new != state_ff.dir);
   end

   rate_prescaler #(
      .DIV_W(PRESC_W)
   ) u_presc (
      .clk(clk),
      .rst_b(rst_b),
      .clear(!vel_run),
      .step(step && vel_run),
      .div_sel(state_ff.ctl.rate_prescale),
      .pulse(presc_pulse)
   );

   // ==================================================================
   // Next state: counters, events and the register port
   // ==================================================================
   always_comb begin
      nxt_state = state_ff;
      if (!(&state_ff.primed)) begin
         nxt_state.primed = state_ff.primed + 2'h1;
      end
      nxt_state.prev = pins;
      wr_pos = bus_req.wr && (bus_req.addr == qpv_pkg::OFS_POSITION);
      home_zero = run && state_ff.ctl.wrap_policy_select && home_rise;
      evt_set = qpv_pkg::EVT_RESET;
      evt_clr = qpv_pkg::EVT_RESET;

      if (run) begin
         nxt_state.dir = dir_new;
      end
      // Index wins over a step in the same cycle under wrap policy one;
      // under policy zero the index never touches the position.
      if (wr_pos) begin
         nxt_state.pos = bus_req.wdata;
      end else if (home_zero) begin
         nxt_state.pos = '0;
      end else if (run && step) begin
         nxt_state.pos = bump(state_ff.pos, state_ff.limit, fwd);
      end

      // Velocity period: the edge landing on expiry still belongs to it.
      if (vel_run) begin
         if (state_ff.timer == '0) begin
            nxt_state.speed = state_ff.count + DW'(presc_pulse);
            nxt_state.count = '0;
            nxt_state.timer = state_ff.reload;
            evt_set[qpv_pkg::EVT_TIMER] = 1'b1;
         end else begin
            nxt_state.timer = state_ff.timer - DW'(1);
            nxt_state.count = state_ff.count + DW'(presc_pulse);
         end
      end

      if (state_ff.ctl.enable && home_rise) begin
         evt_set[qpv_pkg::EVT_INDEX] = 1'b1;
      end
      evt_set[qpv_pkg::EVT_DIR] = dir_flip;
      evt_set[qpv_pkg::EVT_PHASE] = run && phase_err;

      // Register writes; the position write is handled above.
      if (bus_req.wr) begin
         case (bus_req.addr)
            qpv_pkg::OFS_CONTROL: nxt_state.ctl = bus_req.wdata[qpv_pkg::CTL_W-1:0];
            qpv_pkg::OFS_STATUS: nxt_state.phase_seen = 1'b0;
            qpv_pkg::OFS_LIMIT: nxt_state.limit = bus_req.wdata;
            qpv_pkg::OFS_RELOAD: begin
               nxt_state.reload = bus_req.wdata;
               if (!vel_run) begin
                  nxt_state.timer = bus_req.wdata;
               end
            end
            qpv_pkg::OFS_EVT_MASK: nxt_state.mask = bus_req.wdata[qpv_pkg::EVT_W-1:0];
            qpv_pkg::OFS_EVT_CLEAR: evt_clr = bus_req.wdata[qpv_pkg::EVT_W-1:0];
            default: begin
            end
         endcase
      end
      // The status flag is set after the register write, so an error in the
      // same cycle as a status clear is not lost.
      if (run && phase_err) begin
         nxt_state.phase_seen = 1'b1;
      end
      // A new event beats a clear of the same bit in the same cycle.
      nxt_state.raw = (state_ff.raw & ~evt_clr) | evt_set;
      nxt_state.pending = |(nxt_state.raw & nxt_state.mask);

      // Read data stand for exactly the cycle after the strobe.
      nxt_state.rdata = qpv_pkg::WORD_RESET;
      if (bus_req.rd) begin
         case (bus_req.addr)
            qpv_pkg::OFS_CONTROL: nxt_state.rdata = DW'(state_ff.ctl);
            qpv_pkg::OFS_STATUS: begin
               nxt_state.rdata[qpv_pkg::STAT_PHASE] = state_ff.phase_seen;
               nxt_state.rdata[qpv_pkg::STAT_DIR] = state_ff.dir;
            end
            qpv_pkg::OFS_POSITION: nxt_state.rdata = state_ff.pos;
            qpv_pkg::OFS_LIMIT: nxt_state.rdata = state_ff.limit;
            qpv_pkg::OFS_RELOAD: nxt_state.rdata = state_ff.reload;
            qpv_pkg::OFS_TIMER: nxt_state.rdata = state_ff.timer;
            qpv_pkg::OFS_RUNNING: nxt_state.rdata = state_ff.count;
            qpv_pkg::OFS_LAST: nxt_state.rdata = state_ff.speed;
            qpv_pkg::OFS_EVT_MASK: nxt_state.rdata = DW'(state_ff.mask);
            qpv_pkg::OFS_EVT_RAW: nxt_state.rdata = DW'(state_ff.raw);
            qpv_pkg::OFS_EVT_CLEAR: nxt_state.rdata = DW'(state_ff.raw & state_ff.mask);
            default: nxt_state.rdata = qpv_pkg::WORD_RESET;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign rd_data = state_ff.rdata;
   assign event_pending = state_ff.pending;
   assign direction_back = state_ff.dir;

   // ==================================================================
   // Checks
   // ==================================================================
   chk_up_wrap_zero: assert property (@(posedge clk) disable iff (!rst_b)
      run && step && fwd && !wr_pos && !home_zero && state_ff.pos >= state_ff.limit
      |=> state_ff.pos == '0)
      else $error("position did not wrap to zero at the limit");

   chk_down_load_limit: assert property (@(posedge clk) disable iff (!rst_b)
      run && step && !fwd && !wr_pos && !home_zero && state_ff.pos == '0
      |=> state_ff.pos == $past(state_ff.limit))
      else $error("counting down from zero did not load the limit");

   chk_index_zeroes_pos: assert property (@(posedge clk) disable iff (!rst_b)
      home_zero && !wr_pos |=> state_ff.pos == '0)
      else $error("index did not clear the position");

   chk_timer_reload: assert property (@(posedge clk) disable iff (!rst_b)
      vel_run && state_ff.timer == '0
      |=> state_ff.timer == $past(state_ff.reload) && state_ff.raw[qpv_pkg::EVT_TIMER])
      else $error("timer expiry did not reload and flag");

   chk_period_copy: assert property (@(posedge clk) disable iff (!rst_b)
      vel_run && state_ff.timer == '0
      |=> state_ff.count == '0 && state_ff.speed == $past(state_ff.count) + DW'($past(presc_pulse)))
      else $error("period end did not move the running count");

   chk_phase_flag: assert property (@(posedge clk) disable iff (!rst_b)
      run && !state_ff.ctl.input_format_select && a_chg && b_chg
      |=> state_ff.raw[qpv_pkg::EVT_PHASE] && state_ff.phase_seen)
      else $error("double channel change not flagged");

   chk_halt_freezes: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff.ctl.freeze_on_halt && halt_req && !bus_req.wr
      |=> $stable(state_ff.pos) && $stable(state_ff.count) && $stable(state_ff.timer))
      else $error("counters moved during a frozen halt");

   chk_vel_needs_pos: assert property (@(posedge clk) disable iff (!rst_b)
      !state_ff.ctl.enable && !bus_req.wr |=> $stable(state_ff.count) && $stable(state_ff.speed))
      else $error("velocity moved with the position integrator off");

   chk_reverse_flag: assert property (@(posedge clk) disable iff (!rst_b)
      dir_flip |=> state_ff.raw[qpv_pkg::EVT_DIR] && state_ff.dir == !$past(state_ff.dir))
      else $error("reversal not reported");

   chk_event_clear: assert property (@(posedge clk) disable iff (!rst_b)
      bus_req.wr && bus_req.addr == qpv_pkg::OFS_EVT_CLEAR
      && bus_req.wdata[qpv_pkg::EVT_PHASE] && !(run && phase_err)
      |=> !state_ff.raw[qpv_pkg::EVT_PHASE])
      else $error("event clear did not drop the phase error bit");

endmodule

`default_nettype wire

// [pkg/qpv_pkg.sv]
package qpv_pkg;

   // ==================================================================
   // Widths and register map
   // ==================================================================
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int EVT_W = 4;
   localparam int PRESC_W = 3;

   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_POSITION = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_LIMIT = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_TIMER = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_RUNNING = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_LAST = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_EVT_RAW = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 8'h28;

   // ==================================================================
   // Field positions and reset values
   // ==================================================================
   localparam int EVT_INDEX = 0;
   localparam int EVT_TIMER = 1;
   localparam int EVT_DIR = 2;
   localparam int EVT_PHASE = 3;
   localparam int STAT_PHASE = 0;
   localparam int STAT_DIR = 1;
   localparam int CTL_W = 13;
   localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
   localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

   // ==================================================================
   // Carriers
   // ==================================================================
   // Control word, bit 0 at the bottom.
   typedef struct packed {
      logic freeze_on_halt;
      logic invert_home;
      logic invert_chan_b;
      logic invert_chan_a;
      logic [PRESC_W-1:0] rate_prescale;
      logic rate_capture_on;
      logic wrap_policy_select;
      logic edge_count_select;
      logic input_format_select;
      logic swap;
      logic enable;
   } decoder_control_t;

   localparam decoder_control_t CTL_RESET = '0;

   typedef struct packed {
      logic home_pulse_input;
      logic channel_b_input;
      logic channel_a_input;
   } enc_pins_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage

// [rtl/enc_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Two-stage synchroniser for the encoder pins
// ======================================================================
module enc_sync #(
   parameter int W = 3
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } sync_state_t;

   sync_state_t state_ff;
   sync_state_t nxt_state;

   if (W < 1) begin : g_bad_width
      $error("enc_sync needs at least one bit");
   end

   // The first stage feeds only the second; nothing else looks at it.
   always_comb begin
      nxt_state.stage1 = async_in;
      nxt_state.stage2 = state_ff.stage1;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign sync_out = state_ff.stage2;

endmodule

`default_nettype wire

// [rtl/rate_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Power-of-two edge divider in front of the running accumulator
// ======================================================================
module rate_prescaler #(
   parameter int DIV_W = 3
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic step,
   input wire logic [DIV_W-1:0] div_sel,
   output logic pulse
);

   localparam int CNT_W = (1 << DIV_W) - 1;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } presc_state_t;

   presc_state_t state_ff;
   presc_state_t nxt_state;
   logic [CNT_W-1:0] keep_mask;

   if (DIV_W < 1 || DIV_W > 4) begin : g_bad_div
      $error("rate_prescaler supports one to four select bits");
   end

   // Pass every 2^div_sel-th step; clearing restarts the phase of the division.
   always_comb begin
      keep_mask = CNT_W'((64'h1 << div_sel) - 64'h1);
      pulse = step && ((state_ff.cnt & keep_mask) == keep_mask);
      nxt_state = state_ff;
      if (clear) begin
         nxt_state.cnt = '0;
      end else if (step) begin
         nxt_state.cnt = state_ff.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

endmodule

`default_nettype wire

// [test/enc_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Behavioural incremental encoder on the far side of the decoder
// ======================================================================
module enc_model (
   input wire logic clk,
   output var qpv_pkg::enc_pins_t pins
);
   // All pins idle low; every change lands just after a rising edge.
   initial begin
      pins = '0;
   end

   // One gray-code step; callers keep gap at 4 or more so edges never beat clk/4.
   task automatic step(input logic fwd, input int gap);
      @(posedge clk);
      if ((pins.channel_a_input == pins.channel_b_input) == fwd) begin
         pins.channel_a_input <= ~pins.channel_a_input;
      end else begin
         pins.channel_b_input <= ~pins.channel_b_input;
      end
      repeat (gap - 1) @(posedge clk);
   endtask

   // Clock/direction step: the step line is lowered and direction settles well
   // before the rising step edge, whatever level a quadrature test left behind.
   task automatic clkdir(input logic up);
      @(posedge clk);
      pins.channel_b_input <= ~up;
      pins.channel_a_input <= 1'b0;
      repeat (4) @(posedge clk);
      pins.channel_a_input <= 1'b1;
      repeat (4) @(posedge clk);
      pins.channel_a_input <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // Home pulse, long enough to pass the synchroniser.
   task automatic home();
      @(posedge clk);
      pins.home_pulse_input <= 1'b1;
      repeat (4) @(posedge clk);
      pins.home_pulse_input <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // Faulty transition, only when a test asks: both channels flip together.
   task automatic both();
      @(posedge clk);
      pins.channel_a_input <= ~pins.channel_a_input;
      pins.channel_b_input <= ~pins.channel_b_input;
      repeat (4) @(posedge clk);
   endtask
endmodule

`default_nettype wire

// [test/quadrature_position_velocity_tb.sv]
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Self-checking bench for the quadrature position and velocity decoder
// ======================================================================
module quadrature_position_velocity_tb;
   logic clk;
   logic rst_b;
   logic halt_req;
   qpv_pkg::reg_req_t bus_req;
   qpv_pkg::enc_pins_t pins;
   logic [qpv_pkg::DATA_W-1:0] rd_data;
   logic event_pending;
   logic direction_back;
   logic [31:0] got;
   int fails;
   int total_checks;
   int n;

   // 100 MHz system clock.
   initial begin
      clk = 1'b0;
   end
   always #5 clk = ~clk;

   quadrature_position_velocity dut (
      .clk(clk),
      .rst_b(rst_b),
      .enc_pins(pins),
      .halt_req(halt_req),
      .bus_req(bus_req),
      .rd_data(rd_data),
      .event_pending(event_pending),
      .direction_back(direction_back)
   );

   enc_model enc (
      .clk(clk),
      .pins(pins)
   );

   // ===================================================================
   // Bus and comparison tasks
   // ===================================================================
   task automatic check(input logic [31:0] act, input logic [31:0] exp);
      total_checks++;
      if (act !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp);
      end
   endtask

   // Each task waits an edge first, so a strobe is never driven twice in one step.
   task automatic wr(input logic [qpv_pkg::ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req <= '0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just inside it.
   task automatic rd(input logic [qpv_pkg::ADDR_W-1:0] a, output logic [31:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req <= '0;
      #1 d = rd_data;
   endtask

   task automatic rd_chk(input logic [qpv_pkg::ADDR_W-1:0] a, input logic [31:0] exp);
      rd(a, got);
      check(got, exp);
   endtask

   // Steps at the fastest legal rate, then waits out sync and history latency.
   task automatic move(input logic fwd, input int cnt);
      repeat (cnt) enc.step(fwd, 4);
      repeat (6) @(posedge clk);
   endtask

   // One velocity period of 1000 cycles with cnt edges early in it.
   task automatic velo(input logic [2:0] presc, input int cnt, input logic [31:0] exp);
      logic [31:0] base;
      base = 32'h0000_0009 | (32'(presc) << 6);
      wr(qpv_pkg::OFS_CONTROL, base);
      wr(qpv_pkg::OFS_RELOAD, 32'h0000_03E7);
      rd_chk(qpv_pkg::OFS_TIMER, 32'h0000_03E7);
      wr(qpv_pkg::OFS_EVT_CLEAR, 32'h0000_000F);
      wr(qpv_pkg::OFS_CONTROL, base | 32'h0000_0020);
      move(1'b1, cnt);
      rd_chk(qpv_pkg::OFS_RUNNING, exp);
      n = 0;
      got = '0;
      while (got[qpv_pkg::EVT_TIMER] !== 1'b1 && n < 700) begin
         rd(qpv_pkg::OFS_EVT_RAW, got);
         n++;
      end
      check({31'h0, got[qpv_pkg::EVT_TIMER]}, 32'h0000_0001);
      rd_chk(qpv_pkg::OFS_LAST, exp);
      rd_chk(qpv_pkg::OFS_RUNNING, 32'h0000_0000);
   endtask

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ===================================================================
   // Test sequence
   // ===================================================================
   initial begin
      rst_b = 1'b0;
      halt_req = 1'b0;
      bus_req = '0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      rd_chk(qpv_pkg::OFS_CONTROL, 32'h0000_0000);
      rd_chk(qpv_pkg::OFS_EVT_RAW, 32'h0000_0000);
      wr(8'h40, 32'h0000_00FF);
      rd_chk(8'h40, 32'h0000_0000);
      // Both edges counted, then a reversal.
      wr(qpv_pkg::OFS_LIMIT, 32'h0000_00FF);
      wr(qpv_pkg::OFS_CONTROL, 32'h0000_0009);
      move(1'b1, 8);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0008);
      check({31'h0, direction_back}, 32'h0000_0000);
      wr(qpv_pkg::OFS_EVT_CLEAR, 32'h0000_000F);
      move(1'b0, 3);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0005);
      check({31'h0, direction_back}, 32'h0000_0001);
      rd(qpv_pkg::OFS_EVT_RAW, got);
      check({31'h0, got[qpv_pkg::EVT_DIR]}, 32'h0000_0001);
      // Channel A edges only: five steps hold two A edges.
      wr(qpv_pkg::OFS_CONTROL, 32'h0000_0001);
      move(1'b1, 5);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0007);
      // Swapped channels reverse the count.
      wr(qpv_pkg::OFS_CONTROL, 32'h0000_000B);
      move(1'b1, 4);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0003);
      // Inverting A adds one edge, then reverses; dropping it steps down from 0.
      wr(qpv_pkg::OFS_CONTROL, 32'h0000_0209);
      move(1'b1, 4);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0000);
      wr(qpv_pkg::OFS_CONTROL, 32'h0000_0009);
      repeat (6) @(posedge clk);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_00FF);
      // Inverting B alone turns a standing level into one backward edge.
      wr(qpv_pkg::OFS_CONTROL, 32'h0000_0409);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_00FE);
      wr(qpv_pkg::OFS_CONTROL, 32'h0000_0009);
      // Wrap at the limit; index ignored for position.
      wr(qpv_pkg::OFS_LIMIT, 32'h0000_0005);
      wr(qpv_pkg::OFS_POSITION, 32'h0000_0000);
      wr(qpv_pkg::OFS_EVT_CLEAR, 32'h0000_000F);
      move(1'b1, 7);
      enc.home();
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0001);
      rd(qpv_pkg::OFS_EVT_RAW, got);
      check({31'h0, got[qpv_pkg::EVT_INDEX]}, 32'h0000_0001);
      // Index zeroes position; a step down from zero loads the limit.
      wr(qpv_pkg::OFS_CONTROL, 32'h0000_0019);
      enc.home();
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0000);
      move(1'b0, 1);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0005);
      // Inverting a low home pin gives a rising index at once.
      wr(qpv_pkg::OFS_CONTROL, 32'h0000_0819);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0000);
      wr(qpv_pkg::OFS_POSITION, 32'h0000_0005);
      // Freeze during halt, count again after it.
      wr(qpv_pkg::OFS_CONTROL, 32'h0000_1009);
      @(posedge clk) halt_req <= 1'b1;
      move(1'b1, 2);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0005);
      @(posedge clk) halt_req <= 1'b0;
      move(1'b1, 2);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0001);
      // Phase error: no count, masked event, clear.
      wr(qpv_pkg::OFS_EVT_CLEAR, 32'h0000_000F);
      wr(qpv_pkg::OFS_EVT_MASK, 32'h0000_0008);
      wr(qpv_pkg::OFS_STATUS, 32'h0000_0000);
      enc.both();
      repeat (4) @(posedge clk);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0001);
      rd(qpv_pkg::OFS_STATUS, got);
      check({31'h0, got[qpv_pkg::STAT_PHASE]}, 32'h0000_0001);
      check({31'h0, event_pending}, 32'h0000_0001);
      rd_chk(qpv_pkg::OFS_EVT_CLEAR, 32'h0000_0008);
      wr(qpv_pkg::OFS_EVT_CLEAR, 32'h0000_0008);
      repeat (2) @(posedge clk);
      check({31'h0, event_pending}, 32'h0000_0000);
      // Clock/direction: three up, one down.
      wr(qpv_pkg::OFS_LIMIT, 32'h0000_00FF);
      wr(qpv_pkg::OFS_POSITION, 32'h0000_0010);
      wr(qpv_pkg::OFS_CONTROL, 32'h0000_0005);
      repeat (3) enc.clkdir(1'b1);
      enc.clkdir(1'b0);
      repeat (4) @(posedge clk);
      rd_chk(qpv_pkg::OFS_POSITION, 32'h0000_0012);
      // Velocity periods with divide by 1, 4 and 128.
      velo(3'h0, 10, 32'h0000_000A);
      velo(3'h2, 16, 32'h0000_0004);
      velo(3'h7, 130, 32'h0000_0001);
      // Capture without position enable counts nothing.
      wr(qpv_pkg::OFS_CONTROL, 32'h0000_0020);
      move(1'b1, 4);
      rd_chk(qpv_pkg::OFS_RUNNING, 32'h0000_0000);
      close_out();
   end

   // Watchdog well beyond the expected run of a few thousand cycles.
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      close_out();
   end
endmodule

`default_nettype wire
